// ==== logic/dspt_pkg.sv ====
/*
 package for the dual-slope pwm timer: mode codes, fixed tops, prescaler
 settings and the per-channel configuration struct.
 assumes a single 100 MHz clock domain.
*/
package dspt_pkg;
	localparam int          CNT_W        = 16;
	localparam int          NUM_CH       = 3;
	localparam logic [15:0] BOTTOM       = 16'h0000;
	localparam logic [15:0] TOP_8BIT     = 16'h00ff;
	localparam logic [15:0] TOP_9BIT     = 16'h01ff;
	localparam logic [15:0] TOP_10BIT    = 16'h03ff;
	localparam logic [15:0] CNT_RESET    = 16'h0000;
	localparam logic [3:0]  MODE_PC8     = 4'h1;
	localparam logic [3:0]  MODE_PC9     = 4'h2;
	localparam logic [3:0]  MODE_PC10    = 4'h3;
	localparam logic [3:0]  MODE_PFC_CAP = 4'h8;
	localparam logic [3:0]  MODE_PFC_CMP = 4'h9;
	localparam logic [3:0]  MODE_PC_CAP  = 4'ha;
	localparam logic [3:0]  MODE_PC_CMP  = 4'hb;
	localparam logic [1:0]  ACT_OFF      = 2'h0;
	localparam logic [1:0]  ACT_TOGGLE   = 2'h1;
	localparam logic [1:0]  ACT_NONINV   = 2'h2;
	localparam logic [1:0]  ACT_INV      = 2'h3;
	localparam logic [2:0]  PRE_STOP     = 3'h0;
	localparam logic [2:0]  PRE_DIV1     = 3'h1;
	localparam logic [2:0]  PRE_DIV8     = 3'h2;
	localparam logic [2:0]  PRE_DIV64    = 3'h3;
	localparam logic [2:0]  PRE_DIV256   = 3'h4;
	localparam logic [2:0]  PRE_DIV1024  = 3'h5;
	localparam logic [9:0]  DIV8_LAST    = 10'h007;
	localparam logic [9:0]  DIV64_LAST   = 10'h03f;
	localparam logic [9:0]  DIV256_LAST  = 10'h0ff;
	localparam logic [9:0]  DIV1024_LAST = 10'h3ff;
	localparam logic [9:0]  PRE_RESET    = 10'h000;

	typedef struct packed {
		logic [1:0]  action;
		logic        pin_direction_bit;
		logic        wr;
		logic [15:0] wdata;
	} dspt_chan_cfg_t;

	typedef struct packed {
		logic [15:0] count_value;
		logic        down;
		logic        overflow_flag;
		logic        capture_flag;
	} dspt_status_t;
endpackage

// ==== logic/dspt_prescaler.sv ====
/*
 prescaler: one-cycle tick enable from the i/o clock.
 assumes a synchronous clean reset from the top.
*/
`timescale 1ns/10ps
module dspt_prescaler (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [2:0] select,
	output logic            tick
);
	logic [9:0] cnt_q;
	logic [9:0] cnt_d;
	logic       tick_q;
	logic       tick_d;
	logic [9:0] last;

	always_comb begin
		last   = dspt_pkg::PRE_RESET;
		cnt_d  = cnt_q + 10'h001;
		tick_d = 1'b0;
		unique case (select)
			dspt_pkg::PRE_DIV1:    last = dspt_pkg::PRE_RESET;
			dspt_pkg::PRE_DIV8:    last = dspt_pkg::DIV8_LAST;
			dspt_pkg::PRE_DIV64:   last = dspt_pkg::DIV64_LAST;
			dspt_pkg::PRE_DIV256:  last = dspt_pkg::DIV256_LAST;
			dspt_pkg::PRE_DIV1024: last = dspt_pkg::DIV1024_LAST;
			default:               last = dspt_pkg::PRE_RESET;
		endcase
		if (select == dspt_pkg::PRE_STOP || select > dspt_pkg::PRE_DIV1024) begin
			cnt_d = dspt_pkg::PRE_RESET;
		end else if (cnt_q >= last) begin
			cnt_d  = dspt_pkg::PRE_RESET;
			tick_d = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q  <= dspt_pkg::PRE_RESET;
			tick_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign tick = tick_q;
endmodule

// ==== logic/dspt_timer.sv ====
/*
 dual-slope pwm timer: counter, top select, double-buffered compares,
 flags and waveform outputs for NUM_CH channels.
 assumes config ports come from logic on clk; pin side is registered.
*/
`timescale 1ns/10ps
module dspt_timer #(
	parameter int NUM_CH = dspt_pkg::NUM_CH
) (
	input  wire logic                                clk,
	input  wire logic                                rst_n,
	input  wire logic [2:0]                          prescale_select,
	input  wire logic [3:0]                          waveform_mode_select,
	input  wire logic [15:0]                         capture_top_value,
	input  wire dspt_pkg::dspt_chan_cfg_t [NUM_CH-1:0] chan_cfg,
	input  wire logic [NUM_CH-1:0]                   compare_flag_clr,
	input  wire logic                                overflow_flag_clr,
	input  wire logic                                capture_flag_clr,
	output dspt_pkg::dspt_status_t                   status,
	output logic [NUM_CH-1:0]                        compare_flag,
	output logic [NUM_CH-1:0]                        wave_output,
	output logic [NUM_CH-1:0]                        pin_out,
	output logic [NUM_CH-1:0]                        pin_oe_n
);
	function automatic logic is_pc(input logic [3:0] m);
		return m == dspt_pkg::MODE_PC8 || m == dspt_pkg::MODE_PC9 || m == dspt_pkg::MODE_PC10 ||
		       m == dspt_pkg::MODE_PC_CAP || m == dspt_pkg::MODE_PC_CMP;
	endfunction

	function automatic logic is_pfc(input logic [3:0] m);
		return m == dspt_pkg::MODE_PFC_CAP || m == dspt_pkg::MODE_PFC_CMP;
	endfunction

	function automatic logic [15:0] fixed_mask(input logic [3:0] m);
		unique case (m)
			dspt_pkg::MODE_PC8:  return dspt_pkg::TOP_8BIT;
			dspt_pkg::MODE_PC9:  return dspt_pkg::TOP_9BIT;
			dspt_pkg::MODE_PC10: return dspt_pkg::TOP_10BIT;
			default:             return 16'hffff;
		endcase
	endfunction

	logic        rst_s1_q;
	logic        rst_s2_q;
	logic        srst_n;
	logic        tick;
	logic        dual;
	logic        cmp_top;
	logic        cap_top;
	logic [15:0] top;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end
	assign srst_n = rst_s2_q;

	dspt_prescaler u_pre (
		.clk    (clk),
		.rst_n  (srst_n),
		.select (prescale_select),
		.tick   (tick)
	);

	// buffered and active compare values
	logic [NUM_CH-1:0][15:0] buf_q;
	logic [NUM_CH-1:0][15:0] buf_d;
	logic [NUM_CH-1:0][15:0] act_q;
	logic [NUM_CH-1:0][15:0] act_d;

	assign dual    = is_pc(waveform_mode_select) || is_pfc(waveform_mode_select);
	assign cmp_top = waveform_mode_select == dspt_pkg::MODE_PC_CMP || waveform_mode_select == dspt_pkg::MODE_PFC_CMP;
	assign cap_top = waveform_mode_select == dspt_pkg::MODE_PC_CAP || waveform_mode_select == dspt_pkg::MODE_PFC_CAP;

	always_comb begin
		if (cmp_top) begin
			top = act_q[0];
		end else if (cap_top) begin
			top = capture_top_value;
		end else begin
			top = fixed_mask(waveform_mode_select);
		end
	end

	// counter state
	logic [15:0] cnt_q;
	logic [15:0] cnt_d;
	logic        down_q;
	logic        down_d;
	logic        at_top;
	logic        at_bottom;
	logic        load;

	assign at_top    = cnt_q == top;
	assign at_bottom = cnt_q == dspt_pkg::BOTTOM;
	// pc loads at top, pfc at bottom
	assign load      = tick && dual &&
	                   ((is_pc(waveform_mode_select) && at_top) || (is_pfc(waveform_mode_select) && at_bottom));

	always_comb begin
		cnt_d  = cnt_q;
		down_d = down_q;
		if (tick && dual) begin
			if (at_top) begin
				down_d = 1'b1;
				cnt_d  = cnt_q - 16'h0001;
			end else if (at_bottom) begin
				down_d = 1'b0;
				cnt_d  = cnt_q + 16'h0001;
			end else if (down_q) begin
				cnt_d  = cnt_q - 16'h0001;
			end else begin
				// a top lowered below the count runs on and wraps; software must avoid it
				cnt_d  = cnt_q + 16'h0001;
			end
		end
	end

	always_ff @(posedge clk or negedge srst_n) begin
		if (!srst_n) begin
			cnt_q  <= dspt_pkg::CNT_RESET;
			down_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			down_q <= down_d;
		end
	end

	// flags: set wins over clear
	logic              ovf_q;
	logic              ovf_d;
	logic              cap_q;
	logic              cap_d;
	logic [NUM_CH-1:0] cf_q;
	logic [NUM_CH-1:0] cf_d;
	logic              top_evt;
	logic              ovf_evt;

	assign top_evt = tick && dual && at_top;
	assign ovf_evt = tick && dual && at_bottom;

	always_comb begin
		ovf_d = ovf_evt ? 1'b1 : (overflow_flag_clr ? 1'b0 : ovf_q);
		cap_d = (top_evt && cap_top) ? 1'b1 : (capture_flag_clr ? 1'b0 : cap_q);
	end

	// waveform per channel
	logic [NUM_CH-1:0] wave_q;
	logic [NUM_CH-1:0] wave_d;
	logic [NUM_CH-1:0] pin_q;
	logic [NUM_CH-1:0] pin_d;
	logic [NUM_CH-1:0] oe_n_q;
	logic [NUM_CH-1:0] oe_n_d;

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_ch
			logic match;
			logic connected;
			assign match     = tick && dual && cnt_q == act_q[g];
			assign connected = chan_cfg[g].action == dspt_pkg::ACT_NONINV || chan_cfg[g].action == dspt_pkg::ACT_INV ||
			                   (g == 0 && chan_cfg[g].action == dspt_pkg::ACT_TOGGLE && cmp_top);

			always_comb begin
				buf_d[g] = buf_q[g];
				act_d[g] = act_q[g];
				if (chan_cfg[g].wr) begin
					buf_d[g] = chan_cfg[g].wdata & fixed_mask(waveform_mode_select);
				end
				if (load) begin
					act_d[g] = buf_q[g];
				end
				// channel a flag also marks top in compare-a modes
				cf_d[g] = (match || (g == 0 && top_evt && cmp_top)) ? 1'b1 :
				          (compare_flag_clr[g] ? 1'b0 : cf_q[g]);
				wave_d[g] = wave_q[g];
				if (match) begin
					unique case (chan_cfg[g].action)
						dspt_pkg::ACT_NONINV: wave_d[g] = down_d;
						dspt_pkg::ACT_INV:    wave_d[g] = ~down_d;
						dspt_pkg::ACT_TOGGLE: wave_d[g] = (g == 0 && cmp_top) ? ~wave_q[g] : wave_q[g];
						dspt_pkg::ACT_OFF:    wave_d[g] = wave_q[g];
					endcase
				end
				oe_n_d[g] = ~(connected && chan_cfg[g].pin_direction_bit);
				pin_d[g]  = (connected && chan_cfg[g].pin_direction_bit) ? wave_d[g] : 1'b0;
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge srst_n) begin
		if (!srst_n) begin
			buf_q  <= '0;
			act_q  <= '0;
			ovf_q  <= 1'b0;
			cap_q  <= 1'b0;
			cf_q   <= '0;
			wave_q <= '0;
			pin_q  <= '0;
			oe_n_q <= '1;
		end else begin
			buf_q  <= buf_d;
			act_q  <= act_d;
			ovf_q  <= ovf_d;
			cap_q  <= cap_d;
			cf_q   <= cf_d;
			wave_q <= wave_d;
			pin_q  <= pin_d;
			oe_n_q <= oe_n_d;
		end
	end

	assign status.count_value   = cnt_q;
	assign status.down          = down_q;
	assign status.overflow_flag = ovf_q;
	assign status.capture_flag  = cap_q;
	assign compare_flag         = cf_q;
	assign wave_output          = wave_q;
	assign pin_out              = pin_q;
	assign pin_oe_n             = oe_n_q;
endmodule

// ==== test/dspt_timer_props.sv ====
/*
 port assertions for dspt_timer, bound onto every instance.
 assumes one clock domain and at least two channels.
*/
`timescale 1ns/10ps
module dspt_timer_props #(
	parameter int NUM_CH = 3
) (
	input wire logic                                  clk,
	input wire logic                                  rst_n,
	input wire logic [2:0]                            prescale_select,
	input wire logic [3:0]                            waveform_mode_select,
	input wire logic [15:0]                           capture_top_value,
	input wire dspt_pkg::dspt_chan_cfg_t [NUM_CH-1:0] chan_cfg,
	input wire logic [NUM_CH-1:0]                     compare_flag_clr,
	input wire logic                                  overflow_flag_clr,
	input wire dspt_pkg::dspt_status_t                status,
	input wire logic [NUM_CH-1:0]                     compare_flag,
	input wire logic [NUM_CH-1:0]                     wave_output,
	input wire logic [NUM_CH-1:0]                     pin_out,
	input wire logic [NUM_CH-1:0]                     pin_oe_n
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	a_count_one_step: assert property ((status.count_value - $past(status.count_value)) inside {16'h0, 16'h1, 16'hffff})
		else $error("count jumped");
	a_ovf_sticky: assert property ($fell(status.overflow_flag) |-> $past(overflow_flag_clr))
		else $error("overflow flag lost");
	a_cmp_sticky: assert property ($fell(compare_flag[1]) |-> $past(compare_flag_clr[1]))
		else $error("compare flag lost");
	a_ovf_at_bottom: assert property ($rose(status.overflow_flag) |-> $past(status.count_value) == 16'h0000)
		else $error("overflow away from bottom");
	a_top_flag_at_top: assert property ($rose(status.capture_flag) |-> $past(status.count_value) == $past(capture_top_value))
		else $error("capture flag away from top");
	a_top_turn_down: assert property (waveform_mode_select == dspt_pkg::MODE_PC8 && $stable(prescale_select)
		&& prescale_select == dspt_pkg::PRE_DIV1 && status.count_value == 16'h00ff |=> status.count_value == 16'h00fe)
		else $error("top not left downward");
	a_wave_rise_cause: assert property ($rose(wave_output[1]) && $past(chan_cfg[1].action[1]) |-> compare_flag[1]
		&& status.down == ($past(chan_cfg[1].action) == dspt_pkg::ACT_NONINV))
		else $error("wave rose without proper match");
	a_wave_fall_cause: assert property ($fell(wave_output[1]) && $past(chan_cfg[1].action[1]) |-> compare_flag[1]
		&& status.down == ($past(chan_cfg[1].action) == dspt_pkg::ACT_INV))
		else $error("wave fell without proper match");
	a_pin_idle_low: assert property ((pin_out & pin_oe_n) == '0)
		else $error("undriven pin high");
	a_pin_follows: assert property (((pin_out ^ wave_output) & ~pin_oe_n) == '0)
		else $error("driven pin differs from wave");
endmodule
bind dspt_timer dspt_timer_props #(.NUM_CH(NUM_CH)) u_props (.clk(clk), .rst_n(rst_n),
	.prescale_select(prescale_select), .waveform_mode_select(waveform_mode_select),
	.capture_top_value(capture_top_value), .chan_cfg(chan_cfg), .compare_flag_clr(compare_flag_clr),
	.overflow_flag_clr(overflow_flag_clr), .status(status), .compare_flag(compare_flag),
	.wave_output(wave_output), .pin_out(pin_out), .pin_oe_n(pin_oe_n));

// ==== test/dspt_timer_tb.sv ====
/*
 self-checking bench for dspt_timer: fixed and register tops, both dual-slope kinds.
 assumes the timer at /1 except in the prescaler scenario; each scenario starts from a fresh reset except the two compare-a ones, which switch mode mid-run.
*/
`timescale 1ns/10ps
module dspt_timer_tb;
	logic                           clk;
	logic                           rst_n;
	logic                           clr = 1'h0;
	logic [3:0]                     mode;
	logic [15:0]                    cap_top = 16'h0006;
	logic [2:0]                     pre = dspt_pkg::PRE_DIV1;
	dspt_pkg::dspt_chan_cfg_t [2:0] cfg = 60'h0;
	dspt_pkg::dspt_status_t         st;
	logic [2:0]                     cflag;
	logic [2:0]                     wave;
	logic [2:0]                     pin;
	logic [2:0]                     oe_n;
	logic                           w;
	int                             n_mismatch = 0;
	int                             tests_run = 0;
	int                             cycles = 0;
	int                             nt = 0;

	dspt_timer #(.NUM_CH(3)) uut (.clk(clk), .rst_n(rst_n), .prescale_select(pre),
		.waveform_mode_select(mode), .capture_top_value(cap_top), .chan_cfg(cfg),
		.compare_flag_clr({3{clr}}), .overflow_flag_clr(clr), .capture_flag_clr(clr), .status(st),
		.compare_flag(cflag), .wave_output(wave), .pin_out(pin), .pin_oe_n(oe_n));

	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end

	task automatic chk(string n, logic [15:0] e, logic [15:0] s);
		tests_run++;
		if (s !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic cyc(int n);
		repeat (n) @(negedge clk);
	endtask
	// bounded so a stuck counter ends as a mismatch, not a hang
	task automatic till(logic [15:0] v);
		int i;
		i = 0;
		while (st.count_value !== v && i < 3000) begin
			cyc(1);
			i++;
		end
		chk("count reached", v, st.count_value);
	endtask
	task automatic wr(int c, logic [15:0] v);
		cfg[c].wr = 1'h1;
		cfg[c].wdata = v;
		cyc(1);
		cfg[c].wr = 1'h0;
	endtask
	task automatic pulse_clr;
		clr = 1'h1;
		cyc(1);
		clr = 1'h0;
	endtask
	task automatic rst(logic [3:0] m);
		mode = m;
		rst_n = 1'h0;
		cyc(12);
		rst_n = 1'h1;
		cyc(3);
	endtask
	task automatic complete_run;
		$display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			complete_run;
		end
	end

	initial begin
		rst(dspt_pkg::MODE_PC8);
		cfg[0].action = dspt_pkg::ACT_NONINV;
		cfg[1].action = dspt_pkg::ACT_NONINV;
		cfg[1].pin_direction_bit = 1'h1;
		cfg[2].action = dspt_pkg::ACT_INV;
		wr(1, 16'hff02);
		wr(2, 16'h0002);
		till(16'h00ff);
		cyc(1);
		chk("count after top", 16'h00fe, st.count_value);
		chk("down after top", 16'h1, 16'(st.down));
		pulse_clr;
		chk("overflow cleared", 16'h0, 16'(st.overflow_flag));
		till(16'h0001);
		chk("ch1 flag", 16'h1, 16'(cflag[1]));
		chk("ch2 flag", 16'h1, 16'(cflag[2]));
		chk("ch1 wave down", 16'h1, 16'(wave[1]));
		chk("ch2 wave down", 16'h0, 16'(wave[2]));
		chk("ch0 wave at bottom cmp", 16'h0, 16'(wave[0]));
		chk("ch1 pin", 16'h1, 16'(pin[1]));
		chk("ch2 pin", 16'h0, 16'({pin[2], ~oe_n[2]}));
		till(16'h0000);
		cyc(1);
		chk("overflow at bottom", 16'h1, 16'(st.overflow_flag));
		till(16'h0080);
		chk("waves up", 16'h1, 16'({wave[1], wave[2]}));
		rst(dspt_pkg::MODE_PFC_CAP);
		wr(1, 16'h0003);
		till(16'h0006);
		cyc(1);
		chk("pfc count after top", 16'h0005, st.count_value);
		chk("top flag", 16'h1, 16'(st.capture_flag));
		pulse_clr;
		till(16'h0001);
		chk("compare not loaded at top", 16'h0, 16'(wave[1]));
		till(16'h0000);
		cyc(1);
		chk("pfc overflow", 16'h1, 16'(st.overflow_flag));
		till(16'h0006);
		till(16'h0001);
		chk("loaded compare acts", 16'h1, 16'(wave[1]));
		rst(dspt_pkg::MODE_PC_CAP);
		wr(0, 16'h0005);
		till(16'h0006);
		cyc(1);
		chk("pc top flag", 16'h1, 16'(st.capture_flag));
		till(16'h0000);
		till(16'h0002);
		mode = dspt_pkg::MODE_PC_CMP;
		cfg[0].action = dspt_pkg::ACT_TOGGLE;
		till(16'h0005);
		w = wave[0];
		cyc(1);
		chk("compare-a top", 16'h0004, st.count_value);
		till(16'h0000);
		till(16'h0005);
		chk("toggle", {15'h0000, ~w}, 16'(wave[0]));
		pre = dspt_pkg::PRE_DIV8;
		rst(dspt_pkg::MODE_PC_CAP);
		till(16'h0001);
		while (st.count_value == 16'h0001 && nt < 20) begin
			cyc(1);
			nt++;
		end
		chk("ticks per step at /8", 16'h0008, 16'(nt));
		pre = dspt_pkg::PRE_DIV1;
		rst(dspt_pkg::MODE_PC9);
		wr(1, 16'hffff);
		till(16'h01ff);
		cyc(1);
		chk("9-bit count after top", 16'h01fe, st.count_value);
		till(16'h0000);
		till(16'h01ff);
		cyc(1);
		chk("top compare high", 16'h1, 16'(wave[1]));
		till(16'h0000);
		chk("top compare stays high", 16'h1, 16'(wave[1]));
		rst(dspt_pkg::MODE_PC10);
		till(16'h03ff);
		cyc(1);
		chk("10-bit count after top", 16'h03fe, st.count_value);
		rst(dspt_pkg::MODE_PFC_CAP);
		wr(0, 16'h0005);
		till(16'h0006);
		till(16'h0000);
		till(16'h0001);
		// top changes while running, so the freq correct kind is used here
		mode = dspt_pkg::MODE_PFC_CMP;
		pulse_clr;
		till(16'h0005);
		w = wave[0];
		cyc(1);
		chk("pfc compare-a top", 16'h0004, st.count_value);
		chk("compare-a top flag", 16'h1, 16'(cflag[0]));
		chk("pfc toggle", {15'h0000, ~w}, 16'(wave[0]));
		till(16'h0005);
		cyc(1);
		chk("pfc toggle back", {15'h0000, w}, 16'(wave[0]));
		complete_run;
	end
endmodule
